/* rtl/clhp_bus_if.sv */
// interface: parallel host bus between controller and display device
`timescale 1ns/1ns
interface clhp_bus_if;
  logic register_select;
  logic read_write;
  logic strobe;
  logic [7:0] host_wdata;
  logic [7:0] dev_rdata;
  logic dev_oe;
  logic [7:0] host_data_lines;
  logic interface_select_hi;
  logic interface_select_lo;
  assign host_data_lines = dev_oe ? dev_rdata : host_wdata;
  modport device (input register_select, input read_write, input strobe,
    input host_data_lines, input interface_select_hi,
    input interface_select_lo, output dev_rdata, output dev_oe);
  modport host (output register_select, output read_write, output strobe,
    output host_wdata, input host_data_lines,
    output interface_select_hi, output interface_select_lo);
endinterface

/* rtl/clhp_device.sv */
// device end: holding registers, ram pointer, text and glyph rams
`timescale 1ns/1ns
module clhp_device #(
  parameter int SHORT = clhp_pkg::SHORT_CYC,
  parameter int LONG = clhp_pkg::LONG_CYC
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  clhp_bus_if.device bus, // host bus
  input wire logic [6:0] glyph_addr, // display side glyph ram address
  output logic [7:0] glyph_q, // glyph ram row at glyph_addr
  output logic [6:0] line1_head_q, // text address of first visible column
  output logic two_line_q, // line-count bit
  output logic [7:0] shown_code_q // code under display read address
);
  // ==========================================================
  // state
  logic [7:0] text_ram [clhp_pkg::TEXT_DEPTH];
  logic [7:0] glyph_ram [clhp_pkg::GLYPH_DEPTH];
  logic [7:0] cmd_q, data_q, rdata_q;
  logic [6:0] ptr_q;
  logic glyph_sel_q, incr_q, wide_q, half_q, oe_q, reload_q;
  logic [3:0] hi_nib_q;
  logic [6:0] clr_q;
  logic clearing_q;
  logic busy, start, long_op;
  // ==========================================================
  // decode
  wire parallel = {bus.interface_select_hi, bus.interface_select_lo}
                  == 2'b00;
  wire [7:0] bus_byte = wide_q ? bus.host_data_lines
                        : {hi_nib_q, bus.host_data_lines[7:4]};
  wire byte_done = bus.strobe && parallel && (wide_q || half_q);
  // clear walks every text cell; short timer counts must not end it early
  wire dev_busy = busy || clearing_q;
  wire wr_cmd = byte_done && bus.register_select == clhp_pkg::RS_CMD
                && !bus.read_write && !dev_busy;
  wire wr_dat = byte_done && bus.register_select == clhp_pkg::RS_DATA
                && !bus.read_write && !dev_busy;
  wire rd_dat = byte_done && bus.register_select == clhp_pkg::RS_DATA
                && bus.read_write;
  wire [7:0] c = bus_byte;
  wire is_text = c[clhp_pkg::CMD_TEXT_BIT];
  wire is_glyph = !is_text && c[clhp_pkg::CMD_GLYPH_BIT];
  wire is_func = c[7:5] == 3'b001;
  wire is_shift = c[7:4] == 4'b0001;
  wire is_entry = c[7:2] == 6'b000001;
  wire is_home = c[7:1] == 7'b0000001;
  wire is_clear = c == 8'h01;
  wire [6:0] next_ptr = step(ptr_q, incr_q, glyph_sel_q);
  wire [6:0] head_l = wrap_dec(line1_head_q);
  wire [6:0] head_r = wrap_inc(line1_head_q);
  // status: busy on top bit, pointer below
  wire [7:0] status = {dev_busy & parallel, ptr_q};
  // ==========================================================
  // functions
  function automatic logic [6:0] step(input logic [6:0] p,
    input logic up, input logic g);
    logic [6:0] r;
    r = up ? p + 7'h01 : p - 7'h01;
    if (g)
      r = {1'b0, r[5:0]};
    else if (up && p == 7'h27)
      r = clhp_pkg::LINE2_BASE;
    else if (up && p == 7'h67)
      r = 7'h00;
    else if (!up && p == 7'h40)
      r = clhp_pkg::LINE_LAST;
    else if (!up && p == 7'h00)
      r = 7'h67;
    return r;
  endfunction
  // window heads stay within 00..27, wrapping at the line length
  function automatic logic [6:0] wrap_inc(input logic [6:0] h);
    return h == clhp_pkg::LINE_LAST ? 7'h00 : h + 7'h01;
  endfunction
  function automatic logic [6:0] wrap_dec(input logic [6:0] h);
    return h == 7'h00 ? clhp_pkg::LINE_LAST : h - 7'h01;
  endfunction
  function automatic logic [6:0] tidx(input logic [6:0] a);
    return a[6] ? a - clhp_pkg::LINE2_BASE + clhp_pkg::LINE_LEN : a;
  endfunction
  // ==========================================================
  // timing generator times every command and data write
  assign start = wr_cmd || wr_dat;
  assign long_op = wr_cmd && (is_clear || is_home);
  clhp_exec_timer #(.SHORT(SHORT), .LONG(LONG)) u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(start),
    .long_op(long_op),
    .busy(busy)
  );
  // ==========================================================
  // host bus side
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      half_q <= 1'b0;
      hi_nib_q <= 4'h0;
      oe_q <= 1'b0;
    end
    else
    begin
      oe_q <= bus.strobe ? 1'b0 : oe_q;
      if (bus.strobe && parallel && !wide_q)
      begin
        half_q <= !half_q;
        hi_nib_q <= bus.host_data_lines[7:4];
      end
      if (!bus.strobe && bus.read_write && parallel)
        oe_q <= 1'b1;
      else if (!bus.read_write)
        oe_q <= 1'b0;
    end
  end
  // command register only accepts writes; no read path exists
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmd_q <= 8'h00;
      ptr_q <= 7'h00;
      glyph_sel_q <= 1'b0;
      incr_q <= clhp_pkg::RST_INCR;
      wide_q <= clhp_pkg::RST_WIDE;
      two_line_q <= clhp_pkg::RST_TWO_LINE;
      line1_head_q <= 7'h00;
      clearing_q <= 1'b0;
      clr_q <= 7'h00;
    end
    else if (wr_cmd)
    begin
      cmd_q <= c;
      if (is_text)
      begin
        ptr_q <= c[6:0];
        glyph_sel_q <= 1'b0;
      end
      else if (is_glyph)
      begin
        ptr_q <= {1'b0, c[5:0]};
        glyph_sel_q <= 1'b1;
      end
      else if (is_func)
      begin
        wide_q <= c[clhp_pkg::FUNC_DL_POS];
        two_line_q <= c[clhp_pkg::FUNC_N_POS];
      end
      else if (is_shift && c[clhp_pkg::SHIFT_SC_POS])
        line1_head_q <= c[clhp_pkg::SHIFT_RL_POS] ? head_l : head_r;
      else if (is_entry)
        incr_q <= c[clhp_pkg::ENTRY_ID_POS];
      else if (is_home || is_clear)
      begin
        ptr_q <= 7'h00;
        glyph_sel_q <= 1'b0;
        line1_head_q <= 7'h00;
        clearing_q <= is_clear;
        clr_q <= 7'h00;
      end
    end
    else
    begin
      if (wr_dat || rd_dat)
        ptr_q <= next_ptr;
      if (clearing_q)
      begin
        clr_q <= clr_q + 7'h01;
        clearing_q <= clr_q != 7'(clhp_pkg::TEXT_DEPTH - 1);
      end
    end
  end
  // ram ports: data write copies out, data read prefetches next
  always_ff @(posedge hclk)
  begin
    if (clearing_q)
      text_ram[clr_q] <= clhp_pkg::BLANK_CODE;
    else if (wr_dat && !glyph_sel_q)
      text_ram[tidx(ptr_q)] <= c;
    if (wr_dat && glyph_sel_q)
      glyph_ram[ptr_q[5:0]] <= c;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_q <= 8'h00;
      reload_q <= 1'b0;
      rdata_q <= 8'h00;
      glyph_q <= 8'h00;
      shown_code_q <= 8'h00;
    end
    else
    begin
      reload_q <= rd_dat || (wr_cmd && (is_text || is_glyph));
      if (wr_dat)
        data_q <= c;
      else if (reload_q)
        data_q <= glyph_sel_q ? glyph_ram[ptr_q[5:0]]
                  : text_ram[tidx(ptr_q)];
      rdata_q <= (bus.register_select == clhp_pkg::RS_CMD) ? status
                 : data_q;
      glyph_q <= glyph_ram[glyph_addr[5:0]];
      shown_code_q <= text_ram[tidx(line1_head_q)];
    end
  end
  // 4-bit reads send high nibble first, then low nibble
  assign bus.dev_rdata = (wide_q || !half_q) ? rdata_q
                         : {rdata_q[3:0], 4'h0};
  assign bus.dev_oe = oe_q && bus.read_write;
endmodule

/* rtl/clhp_exec_timer.sv */
// execution timer: holds busy for the length of one internal operation
`timescale 1ns/1ns
module clhp_exec_timer #(
  parameter int SHORT = clhp_pkg::SHORT_CYC,
  parameter int LONG = clhp_pkg::LONG_CYC
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  input wire logic start, // pulse: operation begins
  input wire logic long_op, // with start: long operation
  output logic busy // high while operating
);
  localparam int W = $clog2(LONG + 1);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  initial
  begin
    if (SHORT < 1 || LONG < SHORT)
      $error("clhp_exec_timer: bad timing counts");
  end
  assign cnt_d = start ? (long_op ? W'(LONG) : W'(SHORT))
               : (cnt_q != '0 ? cnt_q - W'(1) : cnt_q);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
  assign busy = cnt_q != '0;
endmodule

/* rtl/clhp_host.sv */
// host end: ahb-lite slave that drives the parallel display bus
`timescale 1ns/1ns
module clhp_host #(
  parameter int SETUP = 2
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [7:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic [2:0] hsize, // size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  clhp_bus_if.host bus // display bus
);
  typedef enum logic [1:0] {CLHP_IDLE, CLHP_SET, CLHP_PULSE} clhp_st_t;
  clhp_st_t st_q;
  logic [1:0] cnt_q;
  logic wide_q, half_q, rs_q, rd_q, busy_q, wr_q;
  logic [7:0] byte_q, rb_q;
  logic [7:0] addr_q;
  initial
  begin
    if (SETUP < 1 || SETUP > 3)
      $error("clhp_host: SETUP out of range");
  end
  wire take = hsel && hready && htrans[1];
  wire [7:0] nib_src = half_q ? {byte_q[3:0], 4'h0} : byte_q;
  wire go = wr_q && addr_q == clhp_pkg::REG_CTRL
            && hwdata[clhp_pkg::CTRL_GO_POS];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= CLHP_IDLE;
      cnt_q <= 2'h0;
      wide_q <= clhp_pkg::RST_WIDE;
      half_q <= 1'b0;
      rs_q <= 1'b0;
      rd_q <= 1'b0;
      byte_q <= 8'h00;
      rb_q <= 8'h00;
      busy_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata <= 32'h0;
      bus.strobe <= 1'b0;
      bus.register_select <= 1'b0;
      bus.read_write <= 1'b0;
      bus.host_wdata <= 8'h00;
      bus.interface_select_hi <= 1'b0;
      bus.interface_select_lo <= 1'b0;
    end
    else
    begin
      wr_q <= take && hwrite;
      addr_q <= take ? haddr : addr_q;
      hrdata <= 32'h0;
      if (take && !hwrite)
        unique case (haddr)
          clhp_pkg::REG_STATUS: hrdata <= {30'h0, wide_q, busy_q};
          clhp_pkg::REG_RDATA: hrdata <= {24'h0, rb_q};
          default: hrdata <= 32'h0;
        endcase
      unique case (st_q)
        CLHP_IDLE:
          if (go)
          begin
            rs_q <= hwdata[clhp_pkg::CTRL_RS_POS];
            rd_q <= hwdata[clhp_pkg::CTRL_RD_POS];
            byte_q <= hwdata[7:0];
            half_q <= 1'b0;
            busy_q <= 1'b1;
            cnt_q <= 2'h0;
            st_q <= CLHP_SET;
          end
        CLHP_SET:
        begin
          bus.register_select <= rs_q;
          bus.read_write <= rd_q;
          bus.host_wdata <= nib_src;
          cnt_q <= cnt_q + 2'h1;
          if (cnt_q == 2'(SETUP))
          begin
            cnt_q <= 2'h0;
            st_q <= CLHP_PULSE;
            bus.strobe <= 1'b1;
          end
        end
        CLHP_PULSE:
        begin
          bus.strobe <= 1'b0;
          rb_q <= wide_q ? bus.host_data_lines
                  : (half_q ? {rb_q[7:4], bus.host_data_lines[7:4]}
                     : {bus.host_data_lines[7:4], 4'h0});
          if (!wide_q && !half_q)
          begin
            half_q <= 1'b1;
            st_q <= CLHP_SET;
          end
          else
          begin
            // track the width bit the device will now use
            if (!rs_q && !rd_q && byte_q[7:5] == 3'b001)
              wide_q <= byte_q[clhp_pkg::FUNC_DL_POS];
            busy_q <= 1'b0;
            st_q <= CLHP_IDLE;
          end
        end
        default: st_q <= CLHP_IDLE;
      endcase
    end
  end
  // software polls busy through status reads before each command
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule

/* rtl/clhp_pkg.sv */
// package: constants and types shared by the display host port ends
package clhp_pkg;
  // host bus encodings
  localparam logic RS_CMD = 1'b0;
  localparam logic RS_DATA = 1'b1;
  // text and glyph ram geometry
  localparam int TEXT_DEPTH = 80;
  localparam int GLYPH_DEPTH = 64;
  localparam logic [6:0] LINE2_BASE = 7'h40;
  localparam logic [6:0] LINE_LAST = 7'h27;
  localparam logic [6:0] LINE_LEN = 7'h28;
  // command codes and field positions
  localparam int CMD_CLEAR_BIT = 0;
  localparam int CMD_HOME_BIT = 1;
  localparam int CMD_ENTRY_BIT = 2;
  localparam int CMD_SHIFT_BIT = 4;
  localparam int CMD_FUNC_BIT = 5;
  localparam int CMD_GLYPH_BIT = 6;
  localparam int CMD_TEXT_BIT = 7;
  localparam int ENTRY_ID_POS = 1;
  localparam int SHIFT_SC_POS = 3;
  localparam int SHIFT_RL_POS = 2;
  localparam int FUNC_DL_POS = 4;
  localparam int FUNC_N_POS = 3;
  localparam logic [7:0] BLANK_CODE = 8'h20;
  // reset values
  localparam logic RST_INCR = 1'b1;
  localparam logic RST_WIDE = 1'b1;
  localparam logic RST_TWO_LINE = 1'b0;
  // execution times
  localparam int CLK_NS = 10;
  localparam int SHORT_NS = 18500;
  localparam int LONG_NS = 760000;
  localparam int SHORT_CYC = (SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int LONG_CYC = (LONG_NS + CLK_NS - 1) / CLK_NS;
  // host controller register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RDATA = 8'h08;
  localparam int CTRL_GO_POS = 31;
  localparam int CTRL_RS_POS = 9;
  localparam int CTRL_RD_POS = 8;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_WIDE_POS = 1;
  typedef enum logic [1:0] {CLHP_IF_PAR, CLHP_IF_SER_A, CLHP_IF_SER_B,
                            CLHP_IF_SER_C} clhp_if_t;
endpackage

/* verification/char_lcd_host_port_tb.sv */
// testbench: controller and display device joined over the parallel bus
`timescale 1ns/1ns
module char_lcd_host_port_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [6:0] glyph_addr = 7'h00;
  logic [7:0] glyph_q;
  logic [7:0] shown_code_q;
  logic [6:0] line1_head_q;
  logic two_line_q;
  int mismatches = 0;
  int checks_done = 0;
  logic [7:0] seen_q [$];
  logic [31:0] rd;
  logic [7:0] s;
  clhp_bus_if i_clhp_bus_if ();
  always #5 hclk = ~hclk;
  clhp_host #(.SETUP(2)) i_clhp_host (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bus(i_clhp_bus_if));
  // short execution times keep the run small
  clhp_device #(.SHORT(5), .LONG(20)) i_clhp_device (.hclk(hclk),
    .hresetn(hresetn), .bus(i_clhp_bus_if), .glyph_addr(glyph_addr),
    .glyph_q(glyph_q), .line1_head_q(line1_head_q),
    .two_line_q(two_line_q), .shown_code_q(shown_code_q));
  clhp_properties i_clhp_properties (.hclk(hclk), .hresetn(hresetn),
    .register_select(i_clhp_bus_if.register_select),
    .read_write(i_clhp_bus_if.read_write), .strobe(i_clhp_bus_if.strobe),
    .host_wdata(i_clhp_bus_if.host_wdata),
    .dev_rdata(i_clhp_bus_if.dev_rdata), .dev_oe(i_clhp_bus_if.dev_oe),
    .host_data_lines(i_clhp_bus_if.host_data_lines),
    .interface_select_hi(i_clhp_bus_if.interface_select_hi),
    .interface_select_lo(i_clhp_bus_if.interface_select_lo));
  // ==========================================================
  // data write units seen on the wire
  always @(posedge hclk)
    if (i_clhp_bus_if.strobe === 1'b1 && i_clhp_bus_if.read_write === 1'b0
        && i_clhp_bus_if.register_select === 1'b1)
      seen_q.push_back(i_clhp_bus_if.host_data_lines);
  // ==========================================================
  // common tasks
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // one device bus cycle, then wait until the controller is idle again
  task automatic op(input logic rs, input logic rdb, input logic [7:0] b);
    ahb(1'b1, clhp_pkg::REG_CTRL, {1'b1, 21'h0, rs, rdb, b});
    do ahb(1'b0, clhp_pkg::REG_STATUS, 32'h0);
    while (rd[clhp_pkg::STAT_BUSY_POS] !== 1'b0);
  endtask
  task automatic status(output logic [7:0] v);
    op(clhp_pkg::RS_CMD, 1'b1, 8'h00);
    ahb(1'b0, clhp_pkg::REG_RDATA, 32'h0);
    v = rd[7:0];
  endtask
  // polling busy before every access is the host's duty
  task automatic wait_idle;
    logic [7:0] v;
    do status(v); while (v[7] !== 1'b0);
  endtask
  task automatic cmd(input logic [7:0] b);
    wait_idle();
    op(clhp_pkg::RS_CMD, 1'b0, b);
  endtask
  task automatic wdat(input logic [7:0] b);
    wait_idle();
    op(clhp_pkg::RS_DATA, 1'b0, b);
  endtask
  task automatic rdat(output logic [7:0] v);
    wait_idle();
    op(clhp_pkg::RS_DATA, 1'b1, 8'h00);
    ahb(1'b0, clhp_pkg::REG_RDATA, 32'h0);
    v = rd[7:0];
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    status(s);
    check("status after reset", s, 8'h00);
    ahb(1'b0, clhp_pkg::REG_STATUS, 32'h0);
    check("host status", rd, 32'h2);
    ahb(1'b0, 8'h0C, 32'h0);
    check("unmapped read", rd, 32'h0);
    check("response okay", hresp, 1'b0);
    check("line count", two_line_q, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_busy;
    cmd(8'h01);
    op(clhp_pkg::RS_CMD, 1'b0, 8'h85);
    status(s);
    check("busy, command dropped", s, 8'h80);
    wait_idle();
    status(s);
    check("busy released", s, 8'h00);
    cmd(8'h80);
    rdat(s);
    check("cleared text", s, clhp_pkg::BLANK_CODE);
    $display("test busy done");
  endtask
  task automatic t_text;
    logic [7:0] v;
    cmd(8'h85);
    status(s);
    check("pointer not command", s, 8'h05);
    for (int i = 0; i < 3; i++)
      wdat(8'hA1 + 8'(i));
    status(s);
    check("pointer after writes", s, 8'h08);
    cmd(8'h85);
    for (int i = 0; i < 3; i++)
    begin
      rdat(v);
      check("text read", v, 8'hA1 + 8'(i));
    end
    status(s);
    check("pointer after reads", s, 8'h08);
    $display("test text done");
  endtask
  task automatic t_decr;
    cmd(8'h04);
    cmd(8'h90);
    wdat(8'hC3);
    status(s);
    check("decrement", s, 8'h0F);
    cmd(8'h06);
    $display("test decrement done");
  endtask
  task automatic t_glyph;
    cmd(8'h48);
    wdat(8'h1F);
    status(s);
    check("glyph pointer", s, 8'h09);
    glyph_addr <= 7'h08;
    repeat (2) @(posedge hclk);
    check("glyph row", glyph_q, 8'h1F);
    cmd(8'h88);
    rdat(s);
    check("text untouched", s, clhp_pkg::BLANK_CODE);
    $display("test glyph done");
  endtask
  task automatic t_lines;
    cmd(8'h38);
    wait_idle();
    check("two lines", two_line_q, 1'b1);
    cmd(8'hA7);
    wdat(8'h6B);
    status(s);
    check("line one end", s, 8'h40);
    cmd(8'hE7);
    wdat(8'h6C);
    status(s);
    check("line two end", s, 8'h00);
    $display("test lines done");
  endtask
  task automatic t_shift;
    cmd(8'h02);
    wait_idle();
    check("home head", line1_head_q, 7'h00);
    cmd(8'h18);
    wait_idle();
    check("left shift", line1_head_q, 7'h01);
    cmd(8'h1C);
    cmd(8'h1C);
    wait_idle();
    check("right wrap", line1_head_q, 7'h27);
    check("code at head", shown_code_q, 8'h6B);
    cmd(8'h02);
    $display("test shift done");
  endtask
  task automatic t_nibble;
    cmd(8'h28);
    wait_idle();
    ahb(1'b0, clhp_pkg::REG_STATUS, 32'h0);
    check("narrow mode", rd[clhp_pkg::STAT_WIDE_POS], 1'b0);
    cmd(8'h80);
    wait_idle();
    seen_q.delete();
    wdat(8'h5A);
    check("nibble count", seen_q.size(), 2);
    check("first nibble", seen_q[0][7:4], 4'h5);
    check("second nibble", seen_q[1][7:4], 4'hA);
    cmd(8'h80);
    rdat(s);
    check("narrow read", s, 8'h5A);
    cmd(8'h38);
    $display("test nibble done");
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_busy();
    t_text();
    t_decr();
    t_glyph();
    t_lines();
    t_shift();
    t_nibble();
    give_verdict();
  end
  initial
  begin
    #500000;
    mismatches++;
    give_verdict();
  end
endmodule

/* verification/clhp_properties.sv */
// checker: concurrent properties on the parallel display bus
`timescale 1ns/1ns
module clhp_properties (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  input wire logic register_select, // command or data select
  input wire logic read_write, // high for read
  input wire logic strobe, // transfer pulse
  input wire logic [7:0] host_wdata, // host byte or nibble
  input wire logic [7:0] dev_rdata, // device read byte
  input wire logic dev_oe, // device drives lines
  input wire logic [7:0] host_data_lines, // resolved data lines
  input wire logic interface_select_hi, // interface pin high
  input wire logic interface_select_lo // interface pin low
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // sequences
  sequence s_start;
    $rose(strobe);
  endsequence
  sequence s_held;
    $stable(register_select) && $stable(read_write) && $stable(host_wdata);
  endsequence
  sequence s_read;
    strobe && read_write;
  endsequence
  sequence s_write;
    strobe && !read_write;
  endsequence
  // ==========================================================
  // properties
  a_sel_parallel: assert property (
    {interface_select_hi, interface_select_lo} == 2'b00)
    else $error("interface select pins not parallel");
  a_strobe_pulse: assert property (strobe |=> !strobe [*2])
    else $error("strobe wider than one cycle or too close");
  a_setup_held: assert property (s_start |-> s_held)
    else $error("bus changed at strobe");
  a_setup_deep: assert property (s_start |->
    read_write == $past(read_write, 2) &&
    host_wdata == $past(host_wdata, 2) &&
    register_select == $past(register_select, 2))
    else $error("setup too short before strobe");
  a_read_driven: assert property (
    s_read |-> dev_oe && host_data_lines == dev_rdata)
    else $error("device not driving on read");
  a_status_driven: assert property (
    strobe && !register_select && read_write |-> dev_oe)
    else $error("status read not driven");
  a_write_released: assert property (
    s_write |-> !dev_oe && host_data_lines == host_wdata)
    else $error("device drives during write");
  a_read_stable: assert property (
    strobe && register_select && read_write |-> $stable(dev_rdata))
    else $error("data changed during read strobe");
endmodule
